// [core/dps_pkg.sv]
package dps_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam int DPS_AW = 8;
	localparam logic [7:0] DPS_OFS_OPT = 8'h00;
	localparam logic [7:0] DPS_OFS_SRC = 8'h04;
	localparam logic [7:0] DPS_OFS_DST = 8'h08;
	localparam logic [7:0] DPS_OFS_ARRAY_BYTE_COUNT = 8'h0c;
	localparam logic [7:0] DPS_OFS_ARRAY_COUNT = 8'h10;
	localparam logic [7:0] DPS_OFS_FRAME_COUNT = 8'h14;
	localparam logic [7:0] DPS_OFS_RLD = 8'h18;
	localparam logic [7:0] DPS_OFS_CTRL = 8'h1c;
	localparam logic [7:0] DPS_OFS_STAT = 8'h20;
	localparam logic [7:0] DPS_OFS_PEND_LO = 8'h24;
	localparam logic [7:0] DPS_OFS_PEND_HI = 8'h28;

	// ----------------------------------------
	// Option word fields
	// ----------------------------------------
	localparam int DPS_OPT_SAM = 0;
	localparam int DPS_OPT_DAM = 1;
	localparam int DPS_OPT_SYNC = 2;
	localparam int DPS_OPT_STATIC = 3;
	localparam int DPS_OPT_FW_LSB = 8;
	localparam int DPS_OPT_FW_MSB = 10;
	localparam int DPS_OPT_MODE = 11;
	localparam int DPS_OPT_CODE_LSB = 12;
	localparam int DPS_OPT_CODE_MSB = 17;
	localparam int DPS_OPT_TCINT = 20;
	localparam int DPS_OPT_ITCINT = 21;
	localparam int DPS_OPT_TCCH = 22;
	localparam int DPS_OPT_ITCCH = 23;
	localparam logic [31:0] DPS_OPT_MASK = 32'h00f3ff0f;

	// ----------------------------------------
	// Control and status fields
	// ----------------------------------------
	localparam int DPS_CTRL_TRIG = 0;
	localparam int DPS_CTRL_SER_CLR = 1;
	localparam int DPS_CTRL_EMR_CLR = 2;
	localparam int DPS_CTRL_ERR_CLR = 3;
	localparam int DPS_STAT_SER = 0;
	localparam int DPS_STAT_EMR = 1;
	localparam int DPS_STAT_BUSY = 2;
	localparam int DPS_STAT_ERR = 3;
	localparam int DPS_STAT_MISAL = 4;
	localparam int DPS_STAT_FWRSV = 5;
	localparam int DPS_STAT_CODE_LSB = 8;
	localparam int DPS_ALIGN_BITS = 5;

	// ----------------------------------------
	// Reset values and states
	// ----------------------------------------
	localparam logic [31:0] DPS_RST_WORD = 32'h0;
	localparam logic [15:0] DPS_RST_CNT = 16'h0;
	localparam logic [5:0] DPS_RST_CODE = 6'h0;
	localparam logic [63:0] DPS_RST_PEND = 64'h0;

	typedef enum logic [1:0] {
		DPS_IDLE = 2'b00,
		DPS_SUBMIT = 2'b01,
		DPS_WAIT = 2'b10,
		DPS_CMPL = 2'b11
	} dps_state_e;

	// Null when all counts are zero, dummy when only some are
	function automatic logic [1:0] dps_zero_kind(input logic [15:0] a, input logic [15:0] b,
		input logic [15:0] c);
		logic z_all;
		logic z_any;
		z_all = (a == DPS_RST_CNT) && (b == DPS_RST_CNT) && (c == DPS_RST_CNT);
		z_any = (a == DPS_RST_CNT) || (b == DPS_RST_CNT) || (c == DPS_RST_CNT);
		return {z_all, z_any && !z_all};
	endfunction : dps_zero_kind

endpackage : dps_pkg

// [core/dps_fifo_width.sv]
`timescale 1ns/1ps
module dps_fifo_width
	import dps_pkg::*;
(
	// Option fields
	input wire logic [2:0] code_in,
	input wire logic fifo_mode_in,
	// Decoded width
	output logic [5:0] bytes_out,
	output logic reserved_out
);

	// ----------------------------------------
	// Width decode
	// ----------------------------------------
	// (RULE_03) Width counts only in fifo mode
	always_comb begin
		reserved_out = 1'b0;
		unique case (code_in)
			3'h0: bytes_out = 6'h01;
			3'h1: bytes_out = 6'h02;
			3'h2: bytes_out = 6'h04;
			3'h3: bytes_out = 6'h08;
			3'h4: bytes_out = 6'h10;
			3'h5: bytes_out = 6'h20;
			// (RULE_24) Reserved codes fall back to byte width
			3'h6, 3'h7: begin
				bytes_out = 6'h01;
				reserved_out = fifo_mode_in;
			end
		endcase
		if (!fifo_mode_in) begin
			bytes_out = 6'h00;
		end
	end

endmodule : dps_fifo_width

// [core/dps_count_step.sv]
`timescale 1ns/1ps
module dps_count_step
	import dps_pkg::*;
#(
	parameter int CW = 16
) (
	// Current counts
	input wire logic sync_in,
	input wire logic [CW-1:0] array_count_in,
	input wire logic [CW-1:0] frame_count_in,
	input wire logic [CW-1:0] rld_in,
	// Counts after one submission
	output logic [CW-1:0] array_count_next_out,
	output logic [CW-1:0] frame_count_next_out,
	output logic last_out
);

	localparam logic [CW-1:0] ONE = CW'(1);

	// ----------------------------------------
	// Count update
	// ----------------------------------------
	always_comb begin
		array_count_next_out = array_count_in;
		frame_count_next_out = frame_count_in - ONE;
		last_out = (frame_count_in == ONE);
		if (!sync_in) begin
			if (array_count_in > ONE) begin
				// (RULE_18) One array per submission
				array_count_next_out = array_count_in - ONE;
				frame_count_next_out = frame_count_in;
				last_out = 1'b0;
			end else begin
				// (RULE_19) Frame done, reload arrays
				array_count_next_out = rld_in;
			end
		end
	end

endmodule : dps_count_step

// [core/dps_parameter_ram_set.sv]
// Operation
// (RULE_01) Completion mode clear: complete only after the controller reports data moved.
// (RULE_02) Completion mode set: complete as soon as the request is accepted.
// (RULE_03) FIFO width code selects 8 to 256 bits, only in FIFO mode.
// (RULE_04) Hold flag clear: counts are updated after each accepted request.
// (RULE_05) Hold flag set: entry stays unchanged after a request.
// (RULE_06) Software sets hold for lone or final quick-channel entries only.
// (RULE_07) Sync bit clear: one event moves one array.
// (RULE_08) Sync bit set: one event moves all arrays of a frame.
// (RULE_09) Destination mode picks increment or wrap at FIFO width.
// (RULE_10) Source mode picks increment or wrap at FIFO width.
// (RULE_11) Start addresses are 32-bit byte addresses, unaligned in increment mode.
// (RULE_12) Source FIFO start address needs five zero low bits.
// (RULE_13) Destination FIFO start address needs five zero low bits.
// (RULE_14) Byte count is 16 bits; requests go out only if nonzero.
// (RULE_15) Zero byte count is null or dummy, still completes.
// (RULE_16) Zero array count marks a null or dummy entry.
// (RULE_17) Zero frame count marks a null or dummy entry.
// (RULE_18) Single-array sync decrements the array count per request.
// (RULE_19) At array count end, frame count drops and array count reloads.
// (RULE_20) Frame sync passes full array count; reload unused.
// (RULE_21) All counts zero: set missed flag, keep pending event set.
// (RULE_22) Some counts zero: legal dummy, pending event cleared, no miss.
// (RULE_23) Completion code picks the bit set in pending or chain register.
// (RULE_24) Reserved option bits do nothing and read zero.
`timescale 1ns/1ps
module dps_parameter_ram_set
	import dps_pkg::*;
#(
	parameter int CW = 16
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	// APB slave
	input wire logic [DPS_AW-1:0] paddr_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] pwdata_in,
	output logic pready_out,
	output logic [31:0] prdata_out,
	output logic pslverr_out,
	// Transfer request
	output logic tr_valid_out,
	input wire logic tr_ready_in,
	output logic [31:0] tr_src_out,
	output logic [31:0] tr_dst_out,
	output logic [CW-1:0] tr_array_byte_count_out,
	output logic [CW-1:0] tr_array_count_out,
	output logic tr_sync_out,
	output logic tr_src_mode_out,
	output logic tr_dst_mode_out,
	output logic [5:0] tr_fifo_bytes_out,
	// Transfer controller answers
	input wire logic tr_done_in,
	input wire logic tr_error_in,
	// Chained event
	output logic chain_valid_out,
	output logic [5:0] chain_code_out
);

	logic [31:0] opt_reg;
	logic [31:0] src_reg;
	logic [31:0] dst_reg;
	logic [CW-1:0] array_byte_count_reg;
	logic [CW-1:0] array_count_reg;
	logic [CW-1:0] frame_count_reg;
	logic [CW-1:0] rld_reg;
	logic ser_reg;
	logic emr_reg;
	logic err_reg;
	logic final_reg;
	logic null_reg;
	logic [5:0] code_reg;
	logic [63:0] pend_reg;
	dps_state_e state_reg;
	logic [31:0] rd_data;
	logic rd_ok;
	logic wr_commit;
	logic trig;
	logic accept;
	logic upd;
	logic [1:0] zkind;
	logic [CW-1:0] array_count_next;
	logic [CW-1:0] frame_count_next;
	logic step_last;
	logic [5:0] fifo_bytes;
	logic fw_rsv;
	logic misal;

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	assign wr_commit = psel_in && penable_in && pready_out && pwrite_in;
	assign trig = wr_commit && (paddr_in == DPS_OFS_CTRL) && pwdata_in[DPS_CTRL_TRIG];

	always_comb begin
		rd_data = DPS_RST_WORD;
		rd_ok = 1'b1;
		unique case (paddr_in)
			DPS_OFS_OPT: rd_data = opt_reg;
			DPS_OFS_SRC: rd_data = src_reg;
			DPS_OFS_DST: rd_data = dst_reg;
			DPS_OFS_ARRAY_BYTE_COUNT: rd_data[CW-1:0] = array_byte_count_reg;
			DPS_OFS_ARRAY_COUNT: rd_data[CW-1:0] = array_count_reg;
			DPS_OFS_FRAME_COUNT: rd_data[CW-1:0] = frame_count_reg;
			DPS_OFS_RLD: rd_data[CW-1:0] = rld_reg;
			DPS_OFS_CTRL: rd_data = DPS_RST_WORD;
			DPS_OFS_STAT: begin
				rd_data[DPS_STAT_SER] = ser_reg;
				rd_data[DPS_STAT_EMR] = emr_reg;
				rd_data[DPS_STAT_BUSY] = (state_reg != DPS_IDLE);
				rd_data[DPS_STAT_ERR] = err_reg;
				rd_data[DPS_STAT_MISAL] = misal;
				rd_data[DPS_STAT_FWRSV] = fw_rsv;
				rd_data[DPS_STAT_CODE_LSB +: 6] = code_reg;
			end
			DPS_OFS_PEND_LO: rd_data = pend_reg[31:0];
			DPS_OFS_PEND_HI: rd_data = pend_reg[63:32];
			default: rd_ok = 1'b0;
		endcase
	end

	// Zero-wait: ready rises in the access phase
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pready_out <= 1'b0;
			prdata_out <= DPS_RST_WORD;
			pslverr_out <= 1'b0;
		end else begin
			pready_out <= psel_in && !penable_in;
			if (psel_in && !penable_in) begin
				prdata_out <= pwrite_in ? DPS_RST_WORD : rd_data;
				pslverr_out <= !rd_ok;
			end
		end
	end

	// ----------------------------------------
	// Parameter entry
	// ----------------------------------------
	dps_count_step #(
		.CW(CW)
	) u_step (
		.sync_in(opt_reg[DPS_OPT_SYNC]),
		.array_count_in(array_count_reg),
		.frame_count_in(frame_count_reg),
		.rld_in(rld_reg),
		.array_count_next_out(array_count_next),
		.frame_count_next_out(frame_count_next),
		.last_out(step_last)
	);

	assign accept = tr_valid_out && tr_ready_in;
	// (RULE_04) (RULE_05) Update only when hold flag clear
	assign upd = accept && !opt_reg[DPS_OPT_STATIC];

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			opt_reg <= DPS_RST_WORD;
			src_reg <= DPS_RST_WORD;
			dst_reg <= DPS_RST_WORD;
			array_byte_count_reg <= DPS_RST_CNT;
			array_count_reg <= DPS_RST_CNT;
			frame_count_reg <= DPS_RST_CNT;
			rld_reg <= DPS_RST_CNT;
		end else if (upd) begin
			array_count_reg <= array_count_next;
			frame_count_reg <= frame_count_next;
		end else if (wr_commit) begin
			unique case (paddr_in)
				// (RULE_24) Reserved option bits are not stored
				DPS_OFS_OPT: opt_reg <= pwdata_in & DPS_OPT_MASK;
				// (RULE_11) Full byte addresses, no alignment forced
				DPS_OFS_SRC: src_reg <= pwdata_in;
				DPS_OFS_DST: dst_reg <= pwdata_in;
				DPS_OFS_ARRAY_BYTE_COUNT: array_byte_count_reg <= pwdata_in[CW-1:0];
				DPS_OFS_ARRAY_COUNT: array_count_reg <= pwdata_in[CW-1:0];
				DPS_OFS_FRAME_COUNT: frame_count_reg <= pwdata_in[CW-1:0];
				DPS_OFS_RLD: rld_reg <= pwdata_in[CW-1:0];
				default: ;
			endcase
		end
	end

	// (RULE_12) (RULE_13) Misaligned fifo start address flagged
	assign misal = (opt_reg[DPS_OPT_SAM] && (src_reg[DPS_ALIGN_BITS-1:0] != '0))
		|| (opt_reg[DPS_OPT_DAM] && (dst_reg[DPS_ALIGN_BITS-1:0] != '0));

	dps_fifo_width u_fw (
		.code_in(opt_reg[DPS_OPT_FW_MSB:DPS_OPT_FW_LSB]),
		.fifo_mode_in(opt_reg[DPS_OPT_SAM] || opt_reg[DPS_OPT_DAM]),
		.bytes_out(fifo_bytes),
		.reserved_out(fw_rsv)
	);

	// (RULE_15) (RULE_16) (RULE_17) Zero counts classify the entry
	assign zkind = dps_zero_kind(array_byte_count_reg, array_count_reg, frame_count_reg);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_reg <= DPS_IDLE;
			final_reg <= 1'b0;
			null_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				DPS_IDLE: begin
					if (trig && !ser_reg) begin
						// (RULE_15) (RULE_22) Null and dummy skip the request but complete
						state_reg <= (zkind != 2'h0) ? DPS_CMPL : DPS_SUBMIT;
						final_reg <= 1'b1;
						null_reg <= zkind[1];
					end
				end
				DPS_SUBMIT: begin
					if (accept) begin
						final_reg <= opt_reg[DPS_OPT_STATIC] || step_last;
						// (RULE_02) Early completion on acceptance
						state_reg <= opt_reg[DPS_OPT_MODE] ? DPS_CMPL : DPS_WAIT;
					end
				end
				DPS_WAIT: begin
					// (RULE_01) Normal completion after data moved
					if (tr_done_in) begin
						state_reg <= DPS_CMPL;
					end
				end
				DPS_CMPL: state_reg <= DPS_IDLE;
			endcase
		end
	end

	// (RULE_14) Request built only from a nonzero entry
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tr_valid_out <= 1'b0;
			tr_src_out <= DPS_RST_WORD;
			tr_dst_out <= DPS_RST_WORD;
			tr_array_byte_count_out <= DPS_RST_CNT;
			tr_array_count_out <= DPS_RST_CNT;
			tr_sync_out <= 1'b0;
			tr_src_mode_out <= 1'b0;
			tr_dst_mode_out <= 1'b0;
			tr_fifo_bytes_out <= 6'h00;
		end else if (state_reg == DPS_IDLE && trig && !ser_reg && zkind == 2'b00) begin
			tr_valid_out <= 1'b1;
			tr_src_out <= src_reg;
			tr_dst_out <= dst_reg;
			tr_array_byte_count_out <= array_byte_count_reg;
			// (RULE_07) (RULE_08) (RULE_20) One array or the whole frame
			tr_array_count_out <= opt_reg[DPS_OPT_SYNC] ? array_count_reg : CW'(1);
			tr_sync_out <= opt_reg[DPS_OPT_SYNC];
			// (RULE_09) (RULE_10) Address modes passed on
			tr_src_mode_out <= opt_reg[DPS_OPT_SAM];
			tr_dst_mode_out <= opt_reg[DPS_OPT_DAM];
			tr_fifo_bytes_out <= fifo_bytes;
		end else if (accept) begin
			tr_valid_out <= 1'b0;
		end
	end

	// ----------------------------------------
	// Event flags
	// ----------------------------------------
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ser_reg <= 1'b0;
		end else if (trig && state_reg == DPS_IDLE) begin
			ser_reg <= 1'b1;
		// (RULE_21) Null entry keeps its pending event
		end else if ((state_reg == DPS_SUBMIT && accept) || (state_reg == DPS_CMPL && !null_reg)) begin
			ser_reg <= 1'b0;
		end else if (wr_commit && paddr_in == DPS_OFS_CTRL && pwdata_in[DPS_CTRL_SER_CLR]) begin
			ser_reg <= 1'b0;
		end
	end

	// (RULE_21) Null entry or event while busy marks a miss
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			emr_reg <= 1'b0;
		end else if (trig && (ser_reg || state_reg != DPS_IDLE || zkind[1])) begin
			emr_reg <= 1'b1;
		end else if (wr_commit && paddr_in == DPS_OFS_CTRL && pwdata_in[DPS_CTRL_EMR_CLR]) begin
			emr_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			err_reg <= 1'b0;
		end else if (tr_error_in) begin
			err_reg <= 1'b1;
		end else if (wr_commit && paddr_in == DPS_OFS_CTRL && pwdata_in[DPS_CTRL_ERR_CLR]) begin
			err_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Completion signalling
	// ----------------------------------------
	logic cmpl_int;
	logic cmpl_chain;
	assign cmpl_int = (state_reg == DPS_CMPL)
		&& (final_reg ? opt_reg[DPS_OPT_TCINT] : opt_reg[DPS_OPT_ITCINT]);
	assign cmpl_chain = (state_reg == DPS_CMPL)
		&& (final_reg ? opt_reg[DPS_OPT_TCCH] : opt_reg[DPS_OPT_ITCCH]);

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			code_reg <= DPS_RST_CODE;
		end else if (state_reg == DPS_CMPL) begin
			code_reg <= opt_reg[DPS_OPT_CODE_MSB:DPS_OPT_CODE_LSB];
		end
	end

	// (RULE_23) Code selects the pending bit; set beats clear
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pend_reg <= DPS_RST_PEND;
		end else begin
			for (int i = 0; i < 64; i++) begin
				if (cmpl_int && opt_reg[DPS_OPT_CODE_MSB:DPS_OPT_CODE_LSB] == 6'(i)) begin
					pend_reg[i] <= 1'b1;
				end else if (wr_commit && paddr_in == DPS_OFS_PEND_LO && i < 32) begin
					pend_reg[i] <= pend_reg[i] && !pwdata_in[i % 32];
				end else if (wr_commit && paddr_in == DPS_OFS_PEND_HI && i >= 32) begin
					pend_reg[i] <= pend_reg[i] && !pwdata_in[i % 32];
				end
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			chain_valid_out <= 1'b0;
			chain_code_out <= DPS_RST_CODE;
		end else begin
			chain_valid_out <= cmpl_chain;
			if (cmpl_chain) begin
				chain_code_out <= opt_reg[DPS_OPT_CODE_MSB:DPS_OPT_CODE_LSB];
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_early_cmpl;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(state_reg == DPS_SUBMIT && accept && opt_reg[DPS_OPT_MODE]) |=> state_reg == DPS_CMPL;
	endproperty
	a_early_cmpl: assert property (p_early_cmpl) else $error("early completion late"); // RULE_02

	property p_normal_wait;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		((state_reg == DPS_SUBMIT && accept && !opt_reg[DPS_OPT_MODE]) || (state_reg == DPS_WAIT && !tr_done_in))
			|=> state_reg == DPS_WAIT;
	endproperty
	a_normal_wait: assert property (p_normal_wait) else $error("completed before data done"); // RULE_01

	property p_hold;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(accept && opt_reg[DPS_OPT_STATIC] && !wr_commit) |=> $stable(array_count_reg) && $stable(frame_count_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("held entry changed"); // RULE_05

	property p_a_dec;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(upd && !opt_reg[DPS_OPT_SYNC] && array_count_reg > CW'(1))
			|=> array_count_reg == $past(array_count_reg) - CW'(1) && $stable(frame_count_reg);
	endproperty
	a_a_dec: assert property (p_a_dec) else $error("array count not decremented"); // RULE_18

	property p_reload;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(upd && !opt_reg[DPS_OPT_SYNC] && array_count_reg == CW'(1))
			|=> array_count_reg == $past(rld_reg) && frame_count_reg == $past(frame_count_reg) - CW'(1);
	endproperty
	a_reload: assert property (p_reload) else $error("reload missing"); // RULE_19

	property p_ab;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(upd && opt_reg[DPS_OPT_SYNC]) |-> tr_array_count_out == array_count_reg
			##1 $stable(array_count_reg) && frame_count_reg == $past(frame_count_reg) - CW'(1);
	endproperty
	a_ab: assert property (p_ab) else $error("frame sync update wrong"); // RULE_20

	property p_nonzero;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		tr_valid_out |-> tr_array_byte_count_out != DPS_RST_CNT;
	endproperty
	a_nonzero: assert property (p_nonzero) else $error("zero byte request"); // RULE_14

	property p_null;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(trig && state_reg == DPS_IDLE && !ser_reg && zkind[1])
			|=> emr_reg && ser_reg && !tr_valid_out && state_reg == DPS_CMPL ##1 ser_reg;
	endproperty
	a_null: assert property (p_null) else $error("null entry mishandled"); // RULE_21

	property p_dummy;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(trig && state_reg == DPS_IDLE && !ser_reg && zkind[0] && !emr_reg)
			|=> state_reg == DPS_CMPL && !emr_reg ##1 !ser_reg;
	endproperty
	a_dummy: assert property (p_dummy) else $error("dummy entry mishandled"); // RULE_22

	property p_code;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		cmpl_int |=> pend_reg[$past(opt_reg[DPS_OPT_CODE_MSB:DPS_OPT_CODE_LSB])];
	endproperty
	a_code: assert property (p_code) else $error("pending bit not set"); // RULE_23

	c_null: cover property (@(posedge ref_clk_in) disable iff (!nrst_in)
		trig && state_reg == DPS_IDLE && zkind[1]);
	c_dummy: cover property (@(posedge ref_clk_in) disable iff (!nrst_in)
		state_reg == DPS_IDLE && trig && zkind[0] ##1 state_reg == DPS_CMPL);
	c_early: cover property (@(posedge ref_clk_in) disable iff (!nrst_in)
		accept && opt_reg[DPS_OPT_MODE]);
	c_reload: cover property (@(posedge ref_clk_in) disable iff (!nrst_in)
		upd && !opt_reg[DPS_OPT_SYNC] && array_count_reg == CW'(1));

endmodule : dps_parameter_ram_set

// [verif/dps_tc_model.sv]
`timescale 1ns/1ps
module dps_tc_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Request side
	input wire logic valid_in,
	input wire logic [31:0] src_in,
	input wire logic [31:0] dst_in,
	input wire logic smode_in,
	input wire logic dmode_in,
	// Answers
	output logic ready_out,
	output logic done_out,
	output logic error_out
);
	integer seed = 7;
	int run;
	logic bad;
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ready_out <= 1'b0;
			done_out <= 1'b0;
			error_out <= 1'b0;
			run <= 0;
			bad <= 1'b0;
		end else begin
			// Random stall before accepting
			ready_out <= valid_in && !ready_out && $random(seed) % 2 != 0;
			done_out <= run == 1;
			error_out <= run == 1 && bad;
			if (run > 0)
				run <= run - 1;
			if (valid_in && ready_out) begin
				run <= 4 + ($random(seed) & 7);
				bad <= (smode_in && src_in[4:0] != 5'h0) || (dmode_in && dst_in[4:0] != 5'h0);
			end
		end
	end
endmodule : dps_tc_model

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	import dps_pkg::*;
	logic ref_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [7:0] paddr = 8'h0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic pready, pslverr, slv, tr_valid, tr_ready, tr_sync, tr_sm, tr_dm, tr_done, tr_error, ch_valid;
	logic [31:0] prdata, tr_src, tr_dst, rd_val, a_src, a_dst;
	logic [15:0] tr_array_byte_count, tr_array_count, a_array_byte_count, a_array_count;
	logic [5:0] tr_fb, ch_code, a_code;
	logic [8:0] a_fb;
	int mismatches = 0;
	int tests_run = 0;
	int cyc = 0, acc_n = 0, ch_n = 0, dn_n = 0, acc_cyc, ch_cyc, dn_cyc;
	integer seed = 32'h5a1af828;
	always #5 ref_clk_in = ~ref_clk_in;
	dps_parameter_ram_set #(.CW(16)) u_dps_parameter_ram_set (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
		.paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
		.pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr), .tr_valid_out(tr_valid),
		.tr_ready_in(tr_ready), .tr_src_out(tr_src), .tr_dst_out(tr_dst), .tr_array_byte_count_out(tr_array_byte_count),
		.tr_array_count_out(tr_array_count), .tr_sync_out(tr_sync), .tr_src_mode_out(tr_sm), .tr_dst_mode_out(tr_dm),
		.tr_fifo_bytes_out(tr_fb), .tr_done_in(tr_done), .tr_error_in(tr_error),
		.chain_valid_out(ch_valid), .chain_code_out(ch_code));
	dps_tc_model u_dps_tc_model (.clk_in(ref_clk_in), .nrst_in(nrst_in), .valid_in(tr_valid),
		.src_in(tr_src), .dst_in(tr_dst), .smode_in(tr_sm), .dmode_in(tr_dm), .ready_out(tr_ready),
		.done_out(tr_done), .error_out(tr_error));
	// ----
	// Monitor
	// ----
	always @(posedge ref_clk_in) begin
		cyc <= cyc + 1;
		if (tr_valid && tr_ready) begin
			acc_n <= acc_n + 1;
			acc_cyc <= cyc;
			a_src <= tr_src;
			a_dst <= tr_dst;
			a_array_byte_count <= tr_array_byte_count;
			a_array_count <= tr_array_count;
			a_fb <= {tr_sync, tr_sm, tr_dm, tr_fb};
		end
		if (tr_done) begin
			dn_n <= dn_n + 1;
			dn_cyc <= cyc;
		end
		if (ch_valid) begin
			ch_n <= ch_n + 1;
			ch_cyc <= cyc;
			a_code <= ch_code;
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge ref_clk_in);
		penable <= 1'b1;
		do
			@(posedge ref_clk_in);
		while (pready !== 1'b1);
		rd_val = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk_in);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		check(rd_val, e);
	endtask : rd
	task automatic fire();
		int n;
		int c0;
		n = 0;
		c0 = ch_n;
		wr(DPS_OFS_CTRL, 32'h1);
		while ((ch_n == c0 || dn_n != acc_n) && n < 200) begin
			@(posedge ref_clk_in);
			n++;
		end
		if (n == 200)
			mismatches++;
	endtask : fire
	function automatic logic [7:0] fb_exp(input logic [31:0] o);
		if (!o[0] && !o[1])
			return 8'h0;
		return {o[0], o[1], o[10:8] > 3'h5 ? 6'h1 : 6'h1 << o[10:8]};
	endfunction : fb_exp
	function automatic logic [31:0] nxt(input logic [31:0] o, input logic [15:0] b, c, r);
		if (o[3])
			return {b, c};
		if (o[2])
			return {b, c - 16'h1};
		return b == 16'h1 ? {r, c - 16'h1} : {b - 16'h1, c};
	endfunction : nxt
	task automatic wrap_up();
		$display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	initial begin
		#200000;
		mismatches++;
		wrap_up();
	end
	// ----
	// Scenarios
	// ----
	initial begin
		logic [31:0] channel_options, src, dst, e;
		logic [15:0] ac, bc, cc, rl;
		logic [63:0] pend;
		int n0;
		repeat (3) @(posedge ref_clk_in);
		nrst_in <= 1'b1;
		@(posedge ref_clk_in);
		for (int i = 0; i < 11; i++)
			rd(8'(4 * i), 32'h0);
		apb(8'h2c, 1'b0, 32'h0);
		check({31'h0, slv}, 32'h1);
		wr(DPS_OFS_OPT, 32'hffffffff);
		rd(DPS_OFS_OPT, DPS_OPT_MASK);
		for (int i = 3; i < 7; i++) begin
			wr(8'(4 * i), 32'hffffffff);
			rd(8'(4 * i), 32'h0000ffff);
			wr(8'(4 * i), 32'h0);
		end
		n0 = acc_n;
		wr(DPS_OFS_OPT, 32'h00f00000);
		wr(DPS_OFS_CTRL, 32'h1);
		apb(DPS_OFS_STAT, 1'b0, 32'h0);
		check(rd_val & 32'h7, 32'h3);
		rd(DPS_OFS_PEND_LO, 32'h1);
		wr(DPS_OFS_PEND_LO, 32'h1);
		wr(DPS_OFS_CTRL, 32'h6);
		wr(DPS_OFS_OPT, 32'h00f2a000);
		wr(DPS_OFS_ARRAY_COUNT, 32'h1);
		wr(DPS_OFS_FRAME_COUNT, 32'h1);
		fire();
		check(32'(acc_n), 32'(n0));
		check(32'(a_code), 32'h2a);
		apb(DPS_OFS_STAT, 1'b0, 32'h0);
		check(rd_val & 32'h7, 32'h0);
		rd(DPS_OFS_PEND_HI, 32'h400);
		wr(DPS_OFS_PEND_HI, 32'hffffffff);
		for (int k = 0; k < 14; k++) begin
			// Hold bit drawn both ways; held entries checked for unchanged counts
			channel_options = $random(seed) & 32'h0003ff0f | 32'h00f00000;
			src = $random(seed) & (k[0] ? 32'hffffffe0 : 32'hffffffff);
			dst = $random(seed) & (k[1] ? 32'hffffffe0 : 32'hffffffff);
			ac = 16'($random(seed)) | 16'h1;
			bc = 16'(1 + ($random(seed) & 3));
			cc = 16'(1 + ($random(seed) & 1));
			rl = 16'(1 + ($random(seed) & 3));
			wr(DPS_OFS_OPT, channel_options);
			wr(DPS_OFS_SRC, src);
			wr(DPS_OFS_DST, dst);
			wr(DPS_OFS_ARRAY_BYTE_COUNT, 32'(ac));
			wr(DPS_OFS_ARRAY_COUNT, 32'(bc));
			wr(DPS_OFS_FRAME_COUNT, 32'(cc));
			wr(DPS_OFS_RLD, 32'(rl));
			fire();
			check(a_src, src);
			check(a_dst, dst);
			check(32'(a_array_byte_count), 32'(ac));
			check(32'(a_array_count), channel_options[2] ? 32'(bc) : 32'h1);
			check(32'(a_fb), {23'h0, channel_options[2], fb_exp(channel_options)});
			check(32'(ch_cyc - (channel_options[11] ? acc_cyc : dn_cyc)), 32'h2);
			check(32'(a_code), 32'(channel_options[17:12]));
			apb(DPS_OFS_STAT, 1'b0, 32'h0);
			e = (channel_options[0] && src[4:0] != 5'h0) || (channel_options[1] && dst[4:0] != 5'h0) ? 32'h18 : 32'h0;
			check(rd_val & 32'h18, e);
			check(rd_val & 32'h20, {26'h0, (channel_options[0] || channel_options[1]) && channel_options[10:8] > 3'h5, 5'h0});
			check((rd_val >> 8) & 32'h3f, 32'(channel_options[17:12]));
			e = nxt(channel_options, bc, cc, rl);
			rd(DPS_OFS_ARRAY_COUNT, {16'h0, e[31:16]});
			rd(DPS_OFS_FRAME_COUNT, {16'h0, e[15:0]});
			pend = 64'h1 << channel_options[17:12];
			rd(DPS_OFS_PEND_LO, pend[31:0]);
			rd(DPS_OFS_PEND_HI, pend[63:32]);
			wr(DPS_OFS_PEND_LO, 32'hffffffff);
			wr(DPS_OFS_PEND_HI, 32'hffffffff);
			wr(DPS_OFS_CTRL, 32'h8);
		end
		wrap_up();
	end
endmodule : tb_top
